// *** rtl/msei_defines.vh ***
// constants for the module status and error indicator block
`ifndef MSEI_DEFINES_VH
`define MSEI_DEFINES_VH
// error codes reported to the host
`define MSEI_CODE_NONE 16'h0000
`define MSEI_CODE_SER_HW 16'h1605
`define MSEI_CODE_SER_VOLT 16'h1607
`define MSEI_CODE_SER_CAL 16'h1608
`define MSEI_CODE_MIN_VOLT 16'h1801
`define MSEI_CODE_MIN_HW 16'h1802
`define MSEI_CODE_MIN_CAL 16'h1804
`define MSEI_CODE_RANGE_BASE 16'h1808
// channel layout
`define MSEI_NUM_CH 6
`define MSEI_DATA_W 16
// channel full-scale readings forced on open sensor lines
`define MSEI_CH_MAX 16'h7fff
`define MSEI_CH_MIN 16'h8000
// input modes: plain resistance ranges 0-300 and 0-3000 ohm
`define MSEI_MODE_W 4
`define MSEI_MODE_RES300 4'h8
`define MSEI_MODE_RES3000 4'h9
// blink half period in clock cycles: 250 ms at a 50 MHz clock, sized to the counter
`define MSEI_BLINK_CYC 24'hbebc20
`endif

// *** rtl/msei_blink.v ***
// free running blink phase generator
`timescale 1ns/10ps
`include "msei_defines.vh"
module msei_blink #(
  parameter [23:0] HALF_CYC = `MSEI_BLINK_CYC
)(
  // clock and reset
  input wire sysClk,
  input wire rstN,
  // blink phase
  output reg phase
);
  reg [23:0] count;
  // toggle the phase every half period so the error and conversion indicators blink in step
  always @(posedge sysClk)
  begin
    if (!rstN)
    begin
      count <= 24'h000000;
      phase <= 1'b0;
    end
    else if (count >= HALF_CYC - 24'h000001)
    begin
      count <= 24'h000000;
      phase <= ~phase;
    end
    else
    begin
      count <= count + 24'h000001;
    end
  end
endmodule

// *** rtl/msei_top.v ***
// status indicators, error codes and open-line reading override
`timescale 1ns/10ps
`include "msei_defines.vh"
// Function
// - the run indicator is on while the module runs and off otherwise.
// - the error indicator is steady for serious faults, blinks for minor and channel range faults, else off.
// - the conversion indicator blinks while converting with no range fault, or while running under one; it is off on serious or minor faults and otherwise.
// - serious hardware, voltage, calibration faults give 1605, 1607, 1608 with error on.
// - minor voltage, hardware, calibration faults give 1801, 1802, 1804 with error blinking.
// - an out-of-range channel n gives code 1808 plus n-1 and blinks the error indicator.
// - an open positive or negative line forces the channel reading to its maximum.
// - only an open current-return line forces the channel reading to its minimum.
// - on six channels, the open return line is not detected in the two resistance modes.
module msei_top #(
  parameter [23:0] BLINK_CYC = `MSEI_BLINK_CYC
)(
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // module state
  input wire runState,
  input wire convActive,
  input wire hostRun,
  input wire paramLoadReq,
  // fault inputs, asynchronous
  input wire serHwFail,
  input wire serVoltFail,
  input wire serCalFail,
  input wire minVoltFail,
  input wire minHwFail,
  input wire minCalFail,
  // per channel inputs
  input wire [`MSEI_NUM_CH-1:0] overRange,
  input wire [`MSEI_NUM_CH-1:0] openPos,
  input wire [`MSEI_NUM_CH-1:0] openNeg,
  input wire [`MSEI_NUM_CH-1:0] openRet,
  input wire sixChVariant,
  input wire [`MSEI_NUM_CH*`MSEI_MODE_W-1:0] chMode,
  input wire [`MSEI_NUM_CH*`MSEI_DATA_W-1:0] rawData,
  // indicators
  output reg runLed,
  output reg errLed,
  output reg convLed,
  // host side
  output reg [15:0] errCode,
  output reg paramLoadOk,
  output reg [`MSEI_NUM_CH*`MSEI_DATA_W-1:0] chData
);
  // all fault and line status inputs come from pins: two flop synchroniser
  localparam SW = 11 + 4 * `MSEI_NUM_CH;
  reg [SW-1:0] syncA;
  reg [SW-1:0] syncB;
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      syncA <= {SW{1'b0}};
      syncB <= {SW{1'b0}};
    end
    else
    begin
      syncA <= {runState, convActive, hostRun, paramLoadReq, serHwFail, serVoltFail,
        serCalFail, minVoltFail, minHwFail, minCalFail, sixChVariant,
        overRange, openPos, openNeg, openRet};
      syncB <= syncA;
    end
  end

  wire sRun = syncB[SW-1];
  wire sConv = syncB[SW-2];
  wire sHostRun = syncB[SW-3];
  wire sLoadReq = syncB[SW-4];
  wire sSerHw = syncB[SW-5];
  wire sSerVolt = syncB[SW-6];
  wire sSerCal = syncB[SW-7];
  wire sMinVolt = syncB[SW-8];
  wire sMinHw = syncB[SW-9];
  wire sMinCal = syncB[SW-10];
  wire sSix = syncB[SW-11];
  wire [`MSEI_NUM_CH-1:0] sOver = syncB[4*`MSEI_NUM_CH-1:3*`MSEI_NUM_CH];
  wire [`MSEI_NUM_CH-1:0] sPos = syncB[3*`MSEI_NUM_CH-1:2*`MSEI_NUM_CH];
  wire [`MSEI_NUM_CH-1:0] sNeg = syncB[2*`MSEI_NUM_CH-1:`MSEI_NUM_CH];
  wire [`MSEI_NUM_CH-1:0] sRet = syncB[`MSEI_NUM_CH-1:0];

  // shared blink phase
  wire blink;
  msei_blink #(
    .HALF_CYC(BLINK_CYC)
  ) uBlink (
    .sysClk(sys_clk),
    .rstN(rst_n),
    .phase(blink)
  );

  wire serious = sSerHw | sSerVolt | sSerCal;
  wire minor = sMinVolt | sMinHw | sMinCal;
  wire rangeErr = |sOver;

  // lowest numbered out-of-range channel picks the code
  reg [15:0] rangeCode;
  integer i;
  always @*
  begin
    rangeCode = `MSEI_CODE_NONE;
    for (i = `MSEI_NUM_CH - 1; i >= 0; i = i - 1)
    begin
      if (sOver[i])
        rangeCode = `MSEI_CODE_RANGE_BASE + i[15:0];
    end
  end

  // code selection, serious first, then minor, then channel range
  reg [15:0] next_errCode;
  always @*
  begin
    if (sSerHw)
      next_errCode = `MSEI_CODE_SER_HW;
    else if (sSerVolt)
      next_errCode = `MSEI_CODE_SER_VOLT;
    else if (sSerCal)
      next_errCode = `MSEI_CODE_SER_CAL;
    else if (sMinVolt)
      next_errCode = `MSEI_CODE_MIN_VOLT;
    else if (sMinHw)
      next_errCode = `MSEI_CODE_MIN_HW;
    else if (sMinCal)
      next_errCode = `MSEI_CODE_MIN_CAL;
    else
      next_errCode = rangeCode;
  end

  // indicator levels; a serious or minor fault stops conversion display even if the adc still reports busy
  reg next_errLed;
  reg next_convLed;
  always @*
  begin
    if (serious)
      next_errLed = 1'b1;
    else if (minor | rangeErr)
      next_errLed = blink;
    else
      next_errLed = 1'b0;
    if (serious | minor)
      next_convLed = 1'b0;
    else if (rangeErr)
      next_convLed = sRun & blink;
    else
      next_convLed = sConv & blink;
  end

  // per channel reading override
  wire [`MSEI_NUM_CH*`MSEI_DATA_W-1:0] next_chData;
  genvar g;
  generate
    for (g = 0; g < `MSEI_NUM_CH; g = g + 1)
    begin : gCh
      wire [`MSEI_MODE_W-1:0] mode = chMode[g*`MSEI_MODE_W +: `MSEI_MODE_W];
      // return line blind in resistance modes on the six-channel variant
      wire retBlind = sSix & (mode == `MSEI_MODE_RES300 || mode == `MSEI_MODE_RES3000);
      assign next_chData[g*`MSEI_DATA_W +: `MSEI_DATA_W] =
        (sPos[g] | sNeg[g]) ? `MSEI_CH_MAX :
        (sRet[g] & ~retBlind) ? `MSEI_CH_MIN :
        rawData[g*`MSEI_DATA_W +: `MSEI_DATA_W];
    end
  endgenerate

  // indicator registers; the blink phase is folded in before this stage
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      runLed <= 1'b0;
      errLed <= 1'b0;
      convLed <= 1'b0;
    end
    else
    begin
      runLed <= sRun;
      errLed <= next_errLed;
      convLed <= next_convLed;
    end
  end

  // host side code and download gate
  // the gate follows the synchronised host state, so a download asked for
  // in the last two cycles before the host enters run can still be granted
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      errCode <= `MSEI_CODE_NONE;
      paramLoadOk <= 1'b0;
    end
    else
    begin
      // code of the highest ranked fault
      errCode <= next_errCode;
      // accept download only when host stopped
      paramLoadOk <= sLoadReq & ~sHostRun;
    end
  end

  // readings with open-line overrides
  // rawData is taken as it arrives while the line flags lag by two more
  // edges, so a reading caught as a line breaks can pass unforced briefly
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      chData <= {`MSEI_NUM_CH*`MSEI_DATA_W{1'b0}};
    else
      chData <= next_chData;
  end
endmodule

// *** dv/msei_top_sva.sv ***
// assertion checker for the status and error indicator block
`timescale 1ns/10ps
module msei_sva (
  // clock, reset and inputs
  input wire sys_clk, rst_n, runState, convActive, hostRun, serHwFail, serVoltFail,
  input wire serCalFail, minVoltFail, minHwFail, minCalFail, sixChVariant,
  input wire [5:0] overRange, openPos, openNeg, openRet,
  // outputs
  input wire runLed, errLed, convLed, paramLoadOk,
  input wire [15:0] errCode,
  input wire [95:0] chData
);
  // fault classes; held inputs need 4 samples to reach the outputs
  wire ser = serHwFail | serVoltFail | serCalFail;
  wire quiet = ~ser & ~(minVoltFail | minHwFail | minCalFail);
  // reset seen one edge late: the edge that releases reset still loads zeros
  // into the synchronisers, so no attempt may start on it
  reg rstQ = 1'b0;
  always @(posedge sys_clk)
    rstQ <= rst_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !rstQ);
  a_run_on: assert property (runState[*4] |-> runLed)
    else $error("run led off");
  a_ser_steady: assert property (serHwFail[*4] |-> errLed && !convLed && errCode == 16'h1605)
    else $error("serious fault");
  a_min_code: assert property ((minVoltFail && !ser)[*4] |-> !convLed && errCode == 16'h1801)
    else $error("minor fault");
  a_idle_clear: assert property ((quiet && overRange == 0)[*4] |-> !errLed && errCode == 0)
    else $error("idle error");
  a_range_code: assert property ((quiet && overRange == 6'h04)[*4] |-> errCode == 16'h180a)
    else $error("range code");
  a_open_max: assert property (openPos[0][*4] |-> chData[15:0] == 16'h7fff)
    else $error("open max");
  a_ret_min: assert property ((openRet[2] && !openPos[2] && !openNeg[2] && !sixChVariant)[*4]
    |-> chData[47:32] == 16'h8000)
    else $error("open min");
  a_load_gate: assert property (hostRun[*4] |-> !paramLoadOk)
    else $error("load in run");
  a_conv_stop: assert property ((!runState && !convActive)[*4] |-> !convLed)
    else $error("conv led in stop");
  c_serious: cover property (errCode == 16'h1605);
  c_range6: cover property (errCode == 16'h180d);
  c_load: cover property (paramLoadOk);
endmodule
bind msei_top msei_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .runState(runState),
  .convActive(convActive), .hostRun(hostRun), .serHwFail(serHwFail),
  .serVoltFail(serVoltFail), .serCalFail(serCalFail), .minVoltFail(minVoltFail),
  .minHwFail(minHwFail), .minCalFail(minCalFail), .sixChVariant(sixChVariant),
  .overRange(overRange), .openPos(openPos), .openNeg(openNeg), .openRet(openRet),
  .runLed(runLed), .errLed(errLed), .convLed(convLed), .paramLoadOk(paramLoadOk),
  .errCode(errCode), .chData(chData));

// *** dv/msei_host.sv ***
// host controller model: run state and parameter downloads
`timescale 1ns/10ps
module msei_host (
  input wire sys_clk, wantRun, wantLoad, rude,
  output reg hostRun = 1'b0,
  output reg paramLoadReq = 1'b0
);
  always @(posedge sys_clk)
  begin
    hostRun <= wantRun;
    paramLoadReq <= wantLoad & (rude | ~hostRun); // rude breaks the rule on purpose
  end
endmodule

// *** dv/msei_top_tb.sv ***
// self-checking bench for the status and error indicator block
`timescale 1ns/10ps
module msei_top_tb;
  reg sys_clk = 0, rst_n = 0, runState = 0, convActive = 0, six = 0, wantRun = 0;
  reg wantLoad = 0, rude = 0;
  reg [5:0] flt = 0, rng = 0, oPos = 0, oNeg = 0, oRet = 0;
  reg [23:0] mode = 0;
  wire hostRun, loadReq, runLed, errLed, convLed, loadOk;
  wire [15:0] errCode;
  wire [95:0] chData;
  integer miscompares = 0, checksDone = 0, cycles = 0, i, e, c;
  // rows: serious, minor and range faults, then priority pairs and idle
  reg [27:0] rows [0:15] = '{28'h8001605, 28'h4001607, 28'h2001608, 28'h1001801,
    28'h0801802, 28'h0401804, 28'h0011808, 28'h0021809, 28'h004180a, 28'h008180b,
    28'h010180c, 28'h020180d, 28'h9001605, 28'h1021801, 28'h014180a, 28'h0};
  msei_host HOST (.sys_clk(sys_clk), .wantRun(wantRun), .wantLoad(wantLoad), .rude(rude),
    .hostRun(hostRun), .paramLoadReq(loadReq));
  msei_top #(.BLINK_CYC(24'd4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .runState(runState),
    .convActive(convActive), .hostRun(hostRun), .paramLoadReq(loadReq),
    .serHwFail(flt[5]), .serVoltFail(flt[4]), .serCalFail(flt[3]), .minVoltFail(flt[2]),
    .minHwFail(flt[1]), .minCalFail(flt[0]), .overRange(rng), .openPos(oPos),
    .openNeg(oNeg), .openRet(oRet), .sixChVariant(six), .chMode(mode),
    .rawData({6{16'h0123}}), .runLed(runLed), .errLed(errLed), .convLed(convLed),
    .errCode(errCode), .paramLoadOk(loadOk), .chData(chData));
  // clock and hang guard
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  task chk(input string n, input [95:0] s, x);
  begin
    checksDone = checksDone + 1;
    if (s !== x)
    begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  // count lit cycles over two blink half periods
  task watch;
  begin
    e = 0;
    c = 0;
    repeat (8)
    begin
      @(negedge sys_clk);
      e = e + errLed;
      c = c + convLed;
    end
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // table rows first, then stop state, open lines and downloads
  initial
  begin
    wt(3);
    rst_n <= 1;
    @(negedge sys_clk);
    chk("reset", {runLed, errLed, convLed, loadOk, errCode}, 0);
    chk("reset data", chData, 0);
    @(posedge sys_clk);
    runState <= 1;
    convActive <= 1;
    for (i = 0; i < 16; i = i + 1)
    begin
      flt <= rows[i][27:22];
      rng <= rows[i][21:16];
      wt(5);
      watch;
      chk("code", errCode, rows[i][15:0]);
      chk("err", e, rows[i][27:25] ? 8 : (rows[i][27:16] ? 4 : 0));
      chk("conv", c, rows[i][27:22] ? 0 : 4);
      chk("run", runLed, 1);
      $display("row %0d done", i);
      @(posedge sys_clk);
    end
    runState <= 0;
    rng <= 6'h01;
    wt(5);
    watch;
    chk("stop", {runLed, c[3:0]}, 0);
    @(posedge sys_clk);
    runState <= 1;
    rng <= 0;
    convActive <= 0;
    wt(5);
    watch;
    chk("idle", {runLed, c[3:0]}, 5'h10);
    $display("stop done");
    @(posedge sys_clk);
    oPos <= 6'h11;
    oNeg <= 6'h02;
    oRet <= 6'h3c;
    mode <= 24'h809000;
    six <= 1;
    wt(5);
    @(negedge sys_clk);
    chk("data", chData, {16'h0123, 16'h7fff, 16'h0123, 16'h8000, 16'h7fff, 16'h7fff});
    @(posedge sys_clk);
    six <= 0;
    wt(5);
    @(negedge sys_clk);
    chk("data", chData, {16'h8000, 16'h7fff, 16'h8000, 16'h8000, 16'h7fff, 16'h7fff});
    $display("open done");
    @(posedge sys_clk);
    wantLoad <= 1;
    wt(6);
    @(negedge sys_clk);
    chk("load", loadOk, 1);
    @(posedge sys_clk);
    wantRun <= 1;
    rude <= 1;
    wt(6);
    @(negedge sys_clk);
    chk("load", loadOk, 0);
    $display("load done");
    @(posedge sys_clk);
    // mid-run reset with a serious fault held across it, module stopped
    runState <= 0;
    convActive <= 0;
    flt <= 6'h20;
    wt(5);
    rst_n <= 0;
    wt(3);
    @(negedge sys_clk);
    chk("mid reset", {runLed, errLed, convLed, loadOk, errCode}, 0);
    chk("mid reset data", chData, 0);
    @(posedge sys_clk);
    rst_n <= 1;
    repeat (2) @(negedge sys_clk);
    chk("release 1", {errLed, errCode}, 0);
    @(negedge sys_clk);
    chk("release 2", {errLed, errCode}, 0);
    @(negedge sys_clk);
    chk("release 3", {runLed, errLed, convLed, errCode}, {3'b010, 16'h1605});
    $display("reset done");
    end_of_test;
  end
endmodule
